// File: verilog/pc_card_regs.vh
// strap positions, address layout and state codes for the slot host port
`ifndef PC_CARD_REGS_VH
`define PC_CARD_REGS_VH

`define STRAP_W 16
`define STRAP_MODE_HI 3
`define STRAP_MODE_LO 1
`define STRAP_MODE_SLOT 3'h7
`define STRAP_BYTE_ORDER 4
`define STRAP_WAIT_POL 5
`define STRAP_IF_SET 11
`define STRAP_CLK_HALF 12
`define STRAP_WAIT_DRIVE 15
`define STRAP_RESET 16'h0000

`define ADDR_LOW_W 13
`define ADDR_HIGH_W 11
`define ADDR_FULL_W 24
`define ADDR_REGION_BIT 23
`define ALIAS_OFFSET_W 21

`define ST_IDLE 3'h1
`define ST_BUSY 3'h2
`define ST_HOLD 3'h4

`endif

// File: verilog/sync3.v
// three-stage pin synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pin side
  input wire [W-1:0] d,
  // clock-domain side
  output reg [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit: take the agreed value, otherwise keep the old one
      q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end
endmodule

// File: verilog/pc_card_host_port.v
// slot host port: reset straps, latched address, aliased decode and wait handshake
//
// How it works
// - all sixteen straps captured at reset release
// - slot port only for mode 111 with set
// - byte order strap: 1 little, 0 big
// - wait polarity strap sets wait active level
// - interface-set strap picks alternate or primary group
// - clock halving strap divides host bus clock
// - wait drive strap: always driven while the slot port is enabled, or floating when not selected
// - attribute and IO cycles both accepted
// - low half registers, high half buffer, aliased
// - latch strobe fall captures upper address bits
// - read or write from either strobe pair
// - wait held until data ready or accepted
// - host control pins synchronised before use
`timescale 1ns/1ps
`include "pc_card_regs.vh"
module pc_card_host_port (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // configuration straps
  input wire [15:0] config_straps,
  // host slot pins
  input wire host_bus_clock,
  input wire addr_latch_strobe_in,
  input wire slot_reg_select_n,
  input wire io_read_strobe_in,
  input wire io_write_strobe_in,
  input wire mem_read_strobe_n,
  input wire low_write_strobe,
  input wire high_write_strobe_n,
  input wire [12:0] host_addr,
  input wire [15:0] host_data_in,
  output reg [15:0] host_data_out,
  output reg host_data_oe,
  output reg wait_out,
  output reg wait_oe,
  // captured configuration and host clock tick
  output reg [15:0] straps_q,
  output reg slot_port_enabled,
  output reg little_endian,
  output reg alternate_group,
  output reg host_clk_tick,
  // access request toward registers and display buffer
  output reg req_valid,
  output reg req_write,
  output reg req_display,
  output reg [20:0] req_offset,
  output reg [15:0] req_wdata,
  output reg [1:0] req_byte_en,
  input wire req_done,
  input wire [15:0] req_rdata
);
  reg [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  reg strap_taken_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [10:0] addr_high_q;
  reg ale_prev_q;
  reg clk_prev_q;
  reg half_q;
  reg cyc_write_q;

  // one-hot access states
  localparam [2:0] IDLE = `ST_IDLE;
  localparam [2:0] BUSY = `ST_BUSY;
  localparam [2:0] HOLD = `ST_HOLD;

  wire [7:0] ctl_s;
  wire ale_s = ctl_s[0];
  wire sel_n_s = ctl_s[1];
  wire ior_n_s = ctl_s[2];
  wire iow_n_s = ctl_s[3];
  wire rd_n_s = ctl_s[4];
  wire we0_n_s = ctl_s[5];
  wire hclk_s = ctl_s[6];
  wire we1_n_s = ctl_s[7];

  function [15:0] swap_bytes;
    input [15:0] v;
    input le;
    begin
      swap_bytes = le ? v : {v[7:0], v[15:8]};
    end
  endfunction

  // release reset through two flops
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  sync3 #(.W(8), .INIT(8'hBE)) ctl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({high_write_strobe_n, host_bus_clock, low_write_strobe, mem_read_strobe_n,
        io_write_strobe_in, io_read_strobe_in, slot_reg_select_n, addr_latch_strobe_in}),
    .q(ctl_s)
  );

  // strap capture on the first clock after reset release
  // straps are read only here, so later pin changes cannot move the mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_q <= 1'b0;
      straps_q <= `STRAP_RESET;
      slot_port_enabled <= 1'b0;
      little_endian <= 1'b0;
      alternate_group <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      straps_q <= config_straps;
      slot_port_enabled <= (config_straps[`STRAP_MODE_HI:`STRAP_MODE_LO] == `STRAP_MODE_SLOT)
        && config_straps[`STRAP_IF_SET];
      little_endian <= config_straps[`STRAP_BYTE_ORDER];
      alternate_group <= config_straps[`STRAP_IF_SET];
    end
  end

  wire wait_pol = straps_q[`STRAP_WAIT_POL];
  wire wait_drive = straps_q[`STRAP_WAIT_DRIVE];
  wire clk_half = straps_q[`STRAP_CLK_HALF];

  // host bus clock rising edges, optionally every second one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
      half_q <= 1'b0;
      host_clk_tick <= 1'b0;
    end else begin
      clk_prev_q <= hclk_s;
      if (hclk_s && !clk_prev_q) begin
        half_q <= ~half_q;
      end
      host_clk_tick <= hclk_s && !clk_prev_q && (!clk_half || half_q);
    end
  end

  // upper address bits ride on the low lines while the latch strobe falls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_prev_q <= 1'b0;
      addr_high_q <= 11'h000;
    end else begin
      ale_prev_q <= ale_s;
      if (ale_prev_q && !ale_s) begin
        addr_high_q <= host_addr[`ADDR_HIGH_W-1:0];
      end
    end
  end

  wire rd_req = !ior_n_s || !rd_n_s;
  wire wr_req = !iow_n_s || !we0_n_s;
  wire selected = slot_port_enabled && !sel_n_s;
  wire [23:0] full_addr = {addr_high_q, host_addr};

  always @* begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (selected && (rd_req || wr_req)) begin
          state_d = BUSY;
        end
      end
      BUSY: begin
        if (req_done) begin
          state_d = HOLD;
        end
      end
      HOLD: begin
        if (!rd_req && !wr_req) begin
          state_d = IDLE;
        end
      end
      default: state_d = IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IDLE;
      cyc_write_q <= 1'b0;
      req_valid <= 1'b0;
      req_write <= 1'b0;
      req_display <= 1'b0;
      req_offset <= 21'h000000;
      req_wdata <= 16'h0000;
      req_byte_en <= 2'h0;
      host_data_out <= 16'h0000;
      host_data_oe <= 1'b0;
      wait_out <= 1'b0;
      wait_oe <= 1'b0;
    end else begin
      state_q <= state_d;
      req_valid <= 1'b0;
      if (state_q == IDLE && state_d == BUSY) begin
        req_valid <= 1'b1;
        req_write <= wr_req;
        cyc_write_q <= wr_req;
        req_display <= full_addr[`ADDR_REGION_BIT];
        req_offset <= full_addr[`ALIAS_OFFSET_W-1:0];
        req_wdata <= swap_bytes(host_data_in, little_endian);
        req_byte_en <= {!we1_n_s, !we0_n_s || !iow_n_s || rd_req};
      end
      if (state_q == BUSY && req_done && !cyc_write_q) begin
        host_data_out <= swap_bytes(req_rdata, little_endian);
      end
      host_data_oe <= (state_d == HOLD) && !cyc_write_q && selected;
      // wait active while the access is pending
      wait_out <= (state_d == BUSY) ? wait_pol : ~wait_pol;
      // a low enable leaves the pin floating between this device's cycles
      wait_oe <= slot_port_enabled && (wait_drive || selected);
    end
  end
endmodule

// File: testbench/pc_card_host_port_asserts.sv
// concurrent checks on the slot host port
`timescale 1ns/1ps
module pc_card_host_port_asserts (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // captured configuration
  input wire [15:0] straps_q,
  input wire slot_port_enabled,
  input wire little_endian,
  input wire alternate_group,
  // wait and data pins
  input wire wait_out,
  input wire wait_oe,
  input wire host_data_oe,
  // access handshake
  input wire req_valid,
  input wire req_done
);
  reg [2:0] up_q;
  wire act = wait_oe && (wait_out == straps_q[5]);
  wire on = up_q == 3'h7;
  always @(posedge clk or negedge reset_n)
    if (!reset_n) up_q <= 3'h0;
    else if (!on) up_q <= up_q + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence done_s; act && req_done; endsequence
  sequence free_s; !act; endsequence
  strap_hold_a: assert property (on |-> $stable(straps_q))
    else $error("straps moved");
  slot_sel_a: assert property (on |-> slot_port_enabled == (&straps_q[3:1] && straps_q[11]))
    else $error("slot select");
  strap_fields_a: assert property (on |-> little_endian == straps_q[4]
    && alternate_group == straps_q[11]) else $error("strap fields");
  wait_drive_a: assert property (on && slot_port_enabled && straps_q[15] |-> wait_oe)
    else $error("wait not driven");
  wait_start_a: assert property (req_valid |-> act) else $error("wait start");
  wait_hold_a: assert property (on && act && !req_done |=> act) else $error("wait hold");
  wait_end_a: assert property (done_s |=> free_s) else $error("wait end");
  data_done_a: assert property ($rose(host_data_oe) |-> $past(req_done))
    else $error("data early");
  req_pulse_a: assert property (req_valid |=> !req_valid) else $error("req pulse");
endmodule
bind pc_card_host_port pc_card_host_port_asserts chk (.*);

// File: testbench/access_responder.sv
// far-side responder answering register and display buffer accesses
`timescale 1ns/1ps
module access_responder (
  // clock and answer latency
  input wire clk,
  input wire [3:0] lat,
  // access handshake
  input wire req_valid,
  input wire [20:0] req_offset,
  output reg req_done = 1'b0,
  output reg [15:0] req_rdata = 16'h0000
);
  reg [3:0] cnt = 4'h0;
  // answer after lat cycles, inverted stale data meanwhile
  always @(posedge clk) begin
    req_done <= cnt == 4'h1;
    req_rdata <= (cnt == 4'h1) ? (req_offset[15:0] ^ 16'h5A5A) : ~req_rdata;
    cnt <= req_valid ? lat : cnt - {3'h0, cnt != 4'h0};
  end
endmodule

// File: testbench/pc_card_host_port_tb.sv
// self-checking bench for the slot host port
`timescale 1ns/1ps
module pc_card_host_port_tb;
  reg clk = 1'b0, reset_n = 1'b0, host_bus_clock = 1'b0, addr_latch_strobe_in = 1'b0;
  reg slot_reg_select_n = 1'b1, high_write_strobe_n = 1'b0;
  reg [3:0] stb = 4'hF, lat = 4'h1;
  reg [15:0] config_straps = 16'h0000, host_data_in = 16'h0000, cfg = 16'h0000;
  reg [12:0] host_addr = 13'h0000;
  wire io_read_strobe_in = stb[3], mem_read_strobe_n = stb[2];
  wire io_write_strobe_in = stb[1], low_write_strobe = stb[0];
  wire [15:0] host_data_out, straps_q, req_wdata, req_rdata;
  wire [20:0] req_offset;
  wire [1:0] req_byte_en;
  wire host_data_oe, wait_out, wait_oe, slot_port_enabled, little_endian, alternate_group;
  wire host_clk_tick, req_valid, req_write, req_display, req_done;
  integer num_errors = 0, samples_checked = 0, ticks = 0, i, t0, n;
  reg [17:0] rows [0:3];
  initial forever #25 clk = ~clk;
  initial forever #200 host_bus_clock = ~host_bus_clock;
  always @(posedge clk) ticks <= ticks + host_clk_tick;
  pc_card_host_port DUT (.*);
  access_responder far_end (.clk, .lat, .req_valid, .req_offset, .req_done, .req_rdata);
  task check(input [23:0] seen, input [23:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task limit;
    if (n >= 40) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  endtask
  task boot(input [15:0] s);
    begin
      reset_n = 1'b0;
      config_straps = s;
      cfg = s;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
    end
  endtask
  // stb bits: io read, mem read, io write, low write, all low active
  task access(input [3:0] s, input [10:0] up, input [12:0] lo, input [15:0] d, input [15:0] e);
    begin
      // the latch strobe must outlast the pin filter before it falls
      addr_latch_strobe_in = 1'b1;
      host_addr = {2'h0, up}; // 21-bit window inside the 16M byte block
      repeat (4) @(negedge clk);
      addr_latch_strobe_in = 1'b0;
      repeat (6) @(negedge clk);
      host_addr = lo;
      host_data_in = d;
      // the slot buffer keeps its own card quiet, so only this device answers
      slot_reg_select_n = 1'b0;
      stb = s;
      for (n = 0; n < 40 && req_valid !== 1'b1; n = n + 1) @(negedge clk);
      limit;
      check({req_display, req_offset}, {up[10], up[7:0], lo});
      check({req_write, wait_out, wait_oe}, {s[1:0] != 2'h3, cfg[5], 1'b1});
      check(req_byte_en, 2'h3);
      if (s[1:0] != 2'h3) check(req_wdata, e);
      for (n = 0; n < 40 && wait_out === cfg[5]; n = n + 1) @(negedge clk);
      limit;
      check(wait_out, !cfg[5]);
      if (s[1:0] == 2'h3) check({host_data_oe, host_data_out}, {1'b1, e});
      stb = 4'hF;
      slot_reg_select_n = 1'b1;
      repeat (8) @(negedge clk);
      check(host_data_oe, 1'b0);
    end
  endtask
  initial begin
    // expected slot enable, expected idle wait drive, straps
    rows[0] = 18'h2080E;
    rows[1] = 18'h0100E;
    rows[2] = 18'h0880C;
    rows[3] = 18'h3B83E;
    for (i = 0; i < 4; i = i + 1) begin
      boot(rows[i][15:0]);
      t0 = ticks;
      repeat (160) @(negedge clk);
      check(straps_q, rows[i][15:0]);
      check({slot_port_enabled, wait_oe}, rows[i][17:16]);
      check({little_endian, alternate_group}, {rows[i][4], rows[i][11]});
      check((ticks - t0 + 1) / (rows[i][12] ? 10 : 20), 1);
    end
    boot(16'h080E);
    access(4'h7, 11'h401, 13'h1ABC, 16'h0000, 16'hE660);
    lat = 4'h9;
    access(4'hE, 11'h3C1, 13'h0005, 16'h1234, 16'h3412);
    boot(16'hB83E);
    config_straps = 16'h0000;
    access(4'hB, 11'h400, 13'h0FFF, 16'h0000, 16'h55A5);
    access(4'hD, 11'h002, 13'h1FFF, 16'hBEEF, 16'hBEEF);
    check(straps_q, 16'hB83E);
    end_sim;
  end
endmodule
